// [hw/nest_stack.sv]
// hardware nesting stack of saved channel and priority pairs
`timescale 1ns/1ps
`default_nettype none
module nest_stack
   import vic_pkg::*;
(
   // clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_reset,
   input  wire logic         i_clk_en,
   input  wire logic         i_clear,
   // stack operations
   input  wire logic         i_push,
   input  wire logic         i_pop,
   input  wire nest_entry_s  i_push_data,
   // state
   output nest_entry_s       o_top,
   output logic [DEPTH_W-1:0] o_depth
);

   // =====================================================================
   // storage
   nest_entry_s        stack_mem [STACK_DEPTH];
   logic [DEPTH_W-1:0] depth_reg;

   // entries need no reset; only depth_reg says what is valid
   always_ff @(posedge i_clk_sys) begin
      if (i_clk_en && i_push && depth_reg != DEPTH_W'(STACK_DEPTH)) begin
         stack_mem[depth_reg] <= i_push_data;
      end
   end

   // depth counter; a push into a full stack is dropped
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         depth_reg <= '0;
      end else if (i_clk_en) begin
         if (i_clear) begin
            depth_reg <= '0;
         end else if (i_push && depth_reg != DEPTH_W'(STACK_DEPTH)) begin
            depth_reg <= depth_reg + 1'b1;
         end else if (i_pop && depth_reg != '0) begin
            depth_reg <= depth_reg - 1'b1;
         end
      end
   end

   // =====================================================================
   // outputs
   always_comb begin
      o_top = (depth_reg != '0) ? stack_mem[depth_reg - 1'b1] : '0;
   end
   assign o_depth = depth_reg;

endmodule
`default_nettype wire

// [hw/vectored_irq_controller.sv]
// vectored nested interrupt controller with apb register slave
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module vectored_irq_controller
   import vic_pkg::*;
(
   // clock, reset, clock enable
   input  wire logic         i_clk_sys,
   input  wire logic         i_reset,
   input  wire logic         i_clk_en,
   // apb slave
   input  wire apb_req_s     i_apb,
   output logic [31:0]       o_prdata,
   output logic              o_pready,
   output logic              o_pslverr,
   // interrupt sources, same clock domain
   input  wire logic [NUM_CH-1:0] i_irq_src,
   // processor request
   output logic              o_cpu_interrupt_request_n
);

   // =====================================================================
   // declarations
   logic [31:0]         ctrl_reg;
   logic [31:0]         soft_rst_reg;
   logic [31:0]         vec_base_reg;
   logic [NUM_CH-1:0]   enable_reg;
   logic [NUM_CH-1:0]   pending_reg;
   logic [31:0]         src_cfg_reg [NUM_CH];
   logic [CH_W-1:0]     cur_chan_reg;
   logic [PRIO_W-1:0]   cur_prio_reg;
   logic [31:0]         vector_reg;
   logic [CH_W-1:0]     vec_chan_reg;
   logic [CH_W-1:0]     rd_chan_reg;
   logic                ack_flag_reg;
   logic [CH_W-1:0]     ack_chan_reg;
   irq_state_e          state_reg;
   irq_state_e          state_next;
   logic [31:0]         prdata_reg;
   logic                pready_reg;
   logic                pslverr_reg;
   logic                req_out_reg;

   logic                blk_rst;
   logic                setup;
   logic                access;
   logic                wr;
   logic                rd;
   logic [CH_W-1:0]     src_idx;
   logic                src_hit;
   logic [31:0]         rd_data;
   logic                rd_err;
   logic                win_valid;
   logic [CH_W-1:0]     win_chan;
   logic [PRIO_W-1:0]   win_prio;
   logic                vec_read;
   logic                pend_wr;
   logic                do_push;
   logic                do_pop;
   logic [PRIO_W-1:0]   cur_floor;
   nest_entry_s         stack_top;
   logic [DEPTH_W-1:0]  stack_depth;

   // =====================================================================
   // bus phases and block reset
   // a cleared soft reset bit holds the block in reset, except the soft reset and apb response registers
   assign blk_rst = ~soft_rst_reg[SOFT_RST_BIT];
   assign setup   = i_apb.psel & ~i_apb.penable;
   assign access  = i_apb.psel & i_apb.penable & pready_reg;
   assign wr      = access & i_apb.pwrite & ~pslverr_reg;
   assign rd      = access & ~i_apb.pwrite & ~pslverr_reg;
   assign src_idx = i_apb.paddr[SRC_IDX_LSB +: CH_W];
   assign src_hit = i_apb.paddr[ADDR_W-1:SRC_SEL_LSB] == SRC_CFG_OFS[ADDR_W-1:SRC_SEL_LSB];

   // acknowledge only counts while a request is outstanding
   assign vec_read  = rd && i_apb.paddr == VECTOR_OFS;
   assign pend_wr   = wr && i_apb.paddr == PENDING_OFS;
   assign cur_floor = src_cfg_reg[cur_chan_reg][SRC_PRIO_LSB +: PRIO_W];

   // =====================================================================
   // priority decoder
   // ascending scan with >= lets the higher channel win a tie
   always_comb begin
      win_valid = 1'b0;
      win_chan  = '0;
      win_prio  = '0;
      for (int i = 0; i < NUM_CH; i++) begin
         if (pending_reg[i] &&
             src_cfg_reg[i][SRC_PRIO_LSB +: PRIO_W] > cur_prio_reg &&
             (!win_valid || src_cfg_reg[i][SRC_PRIO_LSB +: PRIO_W] >= win_prio)) begin
            win_valid = 1'b1;
            win_chan  = CH_W'(i);
            win_prio  = src_cfg_reg[i][SRC_PRIO_LSB +: PRIO_W];
         end
      end
   end

   // vector follows the winner every cycle, so it is ready before entry
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         vector_reg   <= '0;
         vec_chan_reg <= '0;
      end else if (i_clk_en) begin
         if (blk_rst) begin
            vector_reg   <= '0;
            vec_chan_reg <= '0;
         end else if (win_valid) begin
            vector_reg   <= {vec_base_reg[31:HALF_W],
                             src_cfg_reg[win_chan][SRC_ADDR_LSB +: HALF_W]};
            vec_chan_reg <= win_chan;
         end
      end
   end

   // =====================================================================
   // request state machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            // no new request while the acknowledge is still being applied
            if (win_valid && !ack_flag_reg) begin
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (vec_read) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         state_reg <= ST_IDLE;
      end else if (i_clk_en) begin
         state_reg <= blk_rst ? ST_IDLE : state_next;
      end
   end

   // output request, masked high while requests are disabled
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         req_out_reg <= 1'b1;
      end else if (i_clk_en) begin
         req_out_reg <= (state_reg != ST_WAIT) | ~ctrl_reg[CTRL_IRQ_EN_BIT];
      end
   end
   assign o_cpu_interrupt_request_n = req_out_reg;

   // =====================================================================
   // acknowledge flag, current channel and current priority
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         ack_flag_reg <= 1'b0;
         ack_chan_reg <= '0;
      end else if (i_clk_en) begin
         if (blk_rst) begin
            ack_flag_reg <= 1'b0;
         end else if (vec_read && state_reg == ST_WAIT) begin
            ack_flag_reg <= 1'b1;
            ack_chan_reg <= rd_chan_reg;
         end else begin
            ack_flag_reg <= 1'b0;
         end
      end
   end

   assign do_push = ack_flag_reg;
   assign do_pop  = pend_wr && i_apb.pwdata[cur_chan_reg] && !ack_flag_reg;

   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         cur_chan_reg <= '0;
         cur_prio_reg <= '0;
      end else if (i_clk_en) begin
         if (blk_rst) begin
            cur_chan_reg <= '0;
            cur_prio_reg <= '0;
         end else if (do_push) begin
            cur_chan_reg <= ack_chan_reg;
            cur_prio_reg <= src_cfg_reg[ack_chan_reg][SRC_PRIO_LSB +: PRIO_W];
         end else if (do_pop && stack_depth != '0) begin
            cur_chan_reg <= stack_top.chan;
            cur_prio_reg <= stack_top.prio;
         end else if (wr && i_apb.paddr == CUR_PRIO_OFS &&
                      i_apb.pwdata[PRIO_W-1:0] >= cur_floor) begin
            cur_prio_reg <= i_apb.pwdata[PRIO_W-1:0];
         end
      end
   end

   // nesting stack
   nest_stack u_stack (
      .i_clk_sys   (i_clk_sys),
      .i_reset     (i_reset),
      .i_clk_en    (i_clk_en),
      .i_clear     (blk_rst),
      .i_push      (do_push),
      .i_pop       (do_pop),
      .i_push_data ({cur_chan_reg, cur_prio_reg}),
      .o_top       (stack_top),
      .o_depth     (stack_depth)
   );

   // =====================================================================
   // pending bits, one flop per channel
   // a source event in the same cycle as a clear keeps the bit set
   for (genvar g = 0; g < NUM_CH; g++) begin : g_pend
      always_ff @(posedge i_clk_sys or posedge i_reset) begin
         if (i_reset) begin
            pending_reg[g] <= 1'b0;
         end else if (i_clk_en) begin
            if (blk_rst) begin
               pending_reg[g] <= 1'b0;
            end else if (i_irq_src[g] && enable_reg[g]) begin
               pending_reg[g] <= 1'b1;
            end else if (pend_wr && i_apb.pwdata[g]) begin
               pending_reg[g] <= 1'b0;
            end
         end
      end
   end

   // =====================================================================
   // software registers
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         ctrl_reg     <= CTRL_RESET;
         vec_base_reg <= VEC_BASE_RESET;
         enable_reg   <= '0;
      end else if (i_clk_en) begin
         if (blk_rst) begin
            ctrl_reg     <= CTRL_RESET;
            vec_base_reg <= VEC_BASE_RESET;
            enable_reg   <= '0;
         end else if (wr) begin
            if (i_apb.paddr == CTRL_OFS) begin
               ctrl_reg <= {31'h0000_0000, i_apb.pwdata[CTRL_IRQ_EN_BIT]};
            end else if (i_apb.paddr == VEC_BASE_OFS) begin
               vec_base_reg <= {i_apb.pwdata[31:HALF_W], 16'h0000};
            end else if (i_apb.paddr == ENABLE_OFS) begin
               enable_reg <= i_apb.pwdata;
            end
         end
      end
   end

   // soft reset lives outside the block reset so it can release it
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         soft_rst_reg <= SOFT_RST_RESET;
      end else if (i_clk_en && wr && i_apb.paddr == SOFT_RST_OFS) begin
         soft_rst_reg <= i_apb.pwdata & SOFT_RST_RESET;
      end
   end

   // per-channel source configuration: routine address and priority
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         for (int i = 0; i < NUM_CH; i++) begin
            src_cfg_reg[i] <= SRC_CFG_RESET;
         end
      end else if (i_clk_en) begin
         if (blk_rst) begin
            for (int i = 0; i < NUM_CH; i++) begin
               src_cfg_reg[i] <= SRC_CFG_RESET;
            end
         end else if (wr && src_hit) begin
            src_cfg_reg[src_idx] <= {i_apb.pwdata[31:HALF_W], 12'h000,
                                     i_apb.pwdata[PRIO_W-1:0]};
         end
      end
   end

   // =====================================================================
   // read decode
   always_comb begin
      rd_data = '0;
      rd_err  = 1'b0;
      if (i_apb.paddr == CTRL_OFS) begin
         rd_data = ctrl_reg;
      end else if (i_apb.paddr == CUR_CHAN_OFS) begin
         rd_data = {20'h00000, stack_depth, 3'h0, cur_chan_reg};
      end else if (i_apb.paddr == CUR_PRIO_OFS) begin
         rd_data = {28'h0000000, cur_prio_reg};
      end else if (i_apb.paddr == VECTOR_OFS) begin
         rd_data = vector_reg;
      end else if (i_apb.paddr == VEC_BASE_OFS) begin
         rd_data = vec_base_reg;
      end else if (i_apb.paddr == ENABLE_OFS) begin
         rd_data = enable_reg;
      end else if (i_apb.paddr == PENDING_OFS) begin
         rd_data = pending_reg;
      end else if (i_apb.paddr == SOFT_RST_OFS) begin
         rd_data = soft_rst_reg;
      end else if (src_hit) begin
         rd_data = src_cfg_reg[src_idx];
      end else begin
         rd_err = 1'b1;
      end
   end

   // no wait state: data captured in setup, pready high in the first access cycle
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         prdata_reg  <= '0;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         rd_chan_reg <= '0;
      end else if (i_clk_en) begin
         pready_reg  <= setup;
         pslverr_reg <= setup & rd_err;
         if (setup) begin
            prdata_reg  <= i_apb.pwrite ? 32'h0000_0000 : rd_data;
            rd_chan_reg <= vec_chan_reg; // channel matching the returned vector
         end
      end
   end
   assign o_prdata  = prdata_reg;
   assign o_pready  = pready_reg;
   assign o_pslverr = pslverr_reg;

endmodule
`default_nettype wire

// [hw/vic_pkg.sv]
// constants, types and register map of the vectored interrupt controller
package vic_pkg;

   // =====================================================================
   // sizes
   localparam int NUM_CH      = 32;
   localparam int CH_W        = 5;
   localparam int PRIO_W      = 4;
   localparam int STACK_DEPTH = 15;
   localparam int DEPTH_W     = 4;
   localparam int ADDR_W      = 12;
   localparam int HALF_W      = 16;

   // =====================================================================
   // register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] CTRL_OFS      = 12'h000;
   localparam logic [ADDR_W-1:0] CUR_CHAN_OFS  = 12'h004;
   localparam logic [ADDR_W-1:0] CUR_PRIO_OFS  = 12'h008;
   localparam logic [ADDR_W-1:0] VECTOR_OFS    = 12'h018;
   localparam logic [ADDR_W-1:0] VEC_BASE_OFS  = 12'h01c;
   localparam logic [ADDR_W-1:0] ENABLE_OFS    = 12'h020;
   localparam logic [ADDR_W-1:0] PENDING_OFS   = 12'h040;
   localparam logic [ADDR_W-1:0] SOFT_RST_OFS  = 12'h044;
   localparam logic [ADDR_W-1:0] SRC_CFG_OFS   = 12'h080;
   localparam int                SRC_SEL_LSB   = 7;
   localparam int                SRC_IDX_LSB   = 2;

   // =====================================================================
   // field positions
   localparam int CTRL_IRQ_EN_BIT = 0;
   localparam int SOFT_RST_BIT    = 14;
   localparam int SRC_PRIO_LSB    = 0;
   localparam int SRC_ADDR_LSB    = 16;
   localparam int CUR_DEPTH_LSB   = 8;

   // =====================================================================
   // reset values
   localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
   localparam logic [31:0] SOFT_RST_RESET = 32'h0000_4000;
   localparam logic [31:0] SRC_CFG_RESET  = 32'h0000_0000;
   localparam logic [31:0] VEC_BASE_RESET = 32'h0000_0000;

   // =====================================================================
   // types
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [CH_W-1:0]   chan;
      logic [PRIO_W-1:0] prio;
   } nest_entry_s;

   typedef enum logic {
      ST_IDLE,
      ST_WAIT
   } irq_state_e;

endpackage

// [tb/periph_flags.sv]
// behavioural peripheral flags that feed the controller's sources
`timescale 1ns/1ps
`default_nettype none
module periph_flags (
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   // set and clear requests from the routine
   input  wire logic [31:0] i_raise,
   input  wire logic [31:0] i_lower,
   // level flags to the controller
   output logic [31:0]      o_flags
);
   // a flag stays up until cleared, so clearing it late re-pends the channel
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         o_flags <= '0;
      end else begin
         o_flags <= (o_flags | i_raise) & ~i_lower;
      end
   end
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking testbench of the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   import vic_pkg::*;
   logic              clk_sys;
   logic              reset;
   logic              clk_en;
   apb_req_s          apb_q;
   logic [31:0]       prdata;
   logic              pready;
   logic              pslverr;
   logic [NUM_CH-1:0] src;
   logic              req_n;
   logic [31:0]       raise;
   logic [31:0]       lower;
   logic [33:0]       exp_q[$];
   logic [33:0]       note;
   logic [15:0]       vaddr[NUM_CH];
   logic [31:0]       seed;
   int                miscompares;
   int                n_tests;
   int                cycles;
   localparam logic [15:0] BASE = 16'hab5e;

   vectored_irq_controller uut (.i_clk_sys(clk_sys), .i_reset(reset), .i_clk_en(clk_en), .i_apb(apb_q),
      .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_irq_src(src),
      .o_cpu_interrupt_request_n(req_n));
   periph_flags flags (.i_clk_sys(clk_sys), .i_reset(reset), .i_raise(raise), .i_lower(lower), .o_flags(src));

   // =====================================================================
   // clock, timeout, helpers
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         conclude();
      end
   end

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // result watcher: each finished read meets the oldest note; bit 33 skips the data
   always @(posedge clk_sys) begin
      if (pready === 1'b1 && apb_q.pwrite === 1'b0) begin
         if (exp_q.size() == 0) chk(34'h0, 34'h1);
         else begin
            note = exp_q.pop_front();
            chk({1'b0, pslverr, note[33] ? note[31:0] : prdata}, {1'b0, note[32:0]});
         end
      end
   end

   // =====================================================================
   // apb master: request held until ready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
      int n;
      n = 0;
      @(posedge clk_sys);
      apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      if (!w) exp_q.push_back(e);
      @(posedge clk_sys);
      apb_q.penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) chk(34'h0, 34'h1);
      apb_q <= '0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 34'h0);
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e});
   endtask

   // random routine address per channel
   task automatic cfg(input int ch, input logic [3:0] pr);
      void'(xs());
      vaddr[ch] = seed[15:0];
      wr(SRC_CFG_OFS + ADDR_W'(ch * 4), {vaddr[ch], 12'h0, pr});
   endtask

   // pulse peripheral flag changes, then let them reach pending
   task automatic ev(input logic [31:0] up, input logic [31:0] dn);
      @(posedge clk_sys);
      raise <= up;
      lower <= dn;
      @(posedge clk_sys);
      raise <= '0;
      lower <= '0;
      repeat (3) @(posedge clk_sys);
   endtask

   task automatic wait_pin(input logic lv);
      int n;
      n = 0;
      while (req_n !== lv && n < 40) begin
         @(posedge clk_sys);
         n++;
      end
      chk({33'h0, req_n}, {33'h0, lv});
   endtask

   // acknowledge: one vector read, then current channel and priority
   task automatic serve(input logic [4:0] ch, input logic [3:0] dep, input logic [3:0] pr);
      rd(VECTOR_OFS, {1'b0, BASE, vaddr[ch]});
      rd(CUR_CHAN_OFS, {1'b0, 20'h0, dep, 3'h0, ch});
      rd(CUR_PRIO_OFS, {1'b0, 28'h0, pr});
   endtask

   // completion: peripheral flag first, then pending bit
   task automatic done(input int ch);
      ev('0, 32'h1 << ch);
      wr(PENDING_OFS, 32'h1 << ch);
   endtask

   // =====================================================================
   // main sequence
   initial begin
      seed = 32'h6c3a;
      reset = 1'b1;
      clk_en = 1'b1;
      apb_q = '0;
      raise = '0;
      lower = '0;
      miscompares = 0;
      n_tests = 0;
      cycles = 0;
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      rd(CTRL_OFS, 33'h0);
      rd(CUR_PRIO_OFS, 33'h0);
      rd(SOFT_RST_OFS, {1'b0, SOFT_RST_RESET});
      rd(12'hffc, {1'b1, 32'h0});
      chk({33'h0, req_n}, 34'h1);
      $display("reset values done");
      wr(VEC_BASE_OFS, {BASE, 16'h0});
      cfg(2, 4'h5);
      cfg(6, 4'h5);
      cfg(3, 4'h0);
      cfg(4, 4'h3);
      cfg(9, 4'h7);
      cfg(11, 4'h7);
      cfg(5, 4'h4);
      wr(ENABLE_OFS, 32'h0000_0a7c);
      ev(32'h1 << 5, '0);
      repeat (6) @(posedge clk_sys);
      chk({33'h0, req_n}, 34'h1);
      wr(CTRL_OFS, 32'h1);
      clk_en <= 1'b0; // frozen: the pin must not follow the new enable yet
      repeat (4) @(posedge clk_sys);
      chk({33'h0, req_n}, 34'h1);
      clk_en <= 1'b1;
      wait_pin(1'b0);
      wr(CTRL_OFS, 32'h0);
      wait_pin(1'b1);
      wr(CTRL_OFS, 32'h1);
      wait_pin(1'b0);
      serve(5, 4'h1, 4'h4);
      done(5);
      rd(CUR_CHAN_OFS, 33'h0);
      $display("global enable done");
      ev(32'h0000_004c, '0);
      wait_pin(1'b0);
      serve(6, 4'h1, 4'h5);
      wait_pin(1'b1);
      done(6);
      rd(PENDING_OFS, 33'h0000_000c);
      wait_pin(1'b0);
      serve(2, 4'h1, 4'h5);
      done(2);
      repeat (8) @(posedge clk_sys);
      chk({33'h0, req_n}, 34'h1);
      $display("tie and priority zero done");
      ev(32'h1 << 4, '0);
      wait_pin(1'b0);
      ev(32'h1 << 9, '0);
      serve(9, 4'h1, 4'h7);
      wr(CTRL_OFS, 32'h0);
      wr(CUR_PRIO_OFS, 32'h5);
      rd(CUR_PRIO_OFS, 33'h7);
      wr(CUR_PRIO_OFS, 32'hc);
      rd(CUR_PRIO_OFS, 33'hc);
      wr(CTRL_OFS, 32'h1);
      done(9);
      wait_pin(1'b0);
      serve(4, 4'h1, 4'h3);
      ev(32'h1 << 11, '0);
      wait_pin(1'b0);
      serve(11, 4'h2, 4'h7);
      done(3);
      rd(CUR_CHAN_OFS, {1'b0, 20'h0, 4'h2, 3'h0, 5'd11});
      done(11);
      rd(CUR_CHAN_OFS, {1'b0, 20'h0, 4'h1, 3'h0, 5'd4});
      rd(CUR_PRIO_OFS, 33'h3);
      done(4);
      rd(CUR_CHAN_OFS, 33'h0);
      $display("nesting done");
      apb(1'b0, VECTOR_OFS, 32'h0, 34'h2_0000_0000);
      rd(CUR_CHAN_OFS, 33'h0);
      rd(CUR_PRIO_OFS, 33'h0);
      $display("idle vector read done");
      ev(32'h1 << 4, '0);
      wait_pin(1'b0);
      wr(SOFT_RST_OFS, 32'h0);
      wait_pin(1'b1);
      rd(ENABLE_OFS, 33'h0);
      rd(PENDING_OFS, 33'h0);
      wr(SOFT_RST_OFS, 32'h0000_4000);
      rd(PENDING_OFS, 33'h0);
      rd(CTRL_OFS, 33'h0);
      rd(SOFT_RST_OFS, 33'h0000_4000);
      ev('0, 32'h1 << 4);
      $display("soft reset done");
      conclude();
   end
endmodule
`default_nettype wire

// [tb/vic_asserts.sv]
// concurrent checks on the ports of the vectored interrupt controller
`timescale 1ns/1ps
`default_nettype none
module vic_asserts
   import vic_pkg::*;
(
   // clock and reset
   input  wire logic              i_clk_sys,
   input  wire logic              i_reset,
   input  wire logic              i_clk_en,
   // apb side
   input  wire apb_req_s          i_apb,
   input  wire logic [31:0]       o_prdata,
   input  wire logic              o_pready,
   input  wire logic              o_pslverr,
   // sources and request
   input  wire logic [NUM_CH-1:0] i_irq_src,
   input  wire logic              o_cpu_interrupt_request_n
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_reset);

   // =====================================================================
   // helper decode of bus activity
   logic setup;
   logic acc;
   logic vec_rd;
   logic mapped;
   logic en_q;
   logic srst_q;
   assign setup  = i_apb.psel & ~i_apb.penable & i_clk_en;
   assign acc    = i_apb.psel & i_apb.penable & o_pready;
   assign vec_rd = acc & ~i_apb.pwrite & (i_apb.paddr == VECTOR_OFS);
   assign mapped = (i_apb.paddr[11:SRC_SEL_LSB] == 5'h01) || (i_apb.paddr inside {CTRL_OFS, CUR_CHAN_OFS,
                   CUR_PRIO_OFS, VECTOR_OFS, VEC_BASE_OFS, ENABLE_OFS, PENDING_OFS, SOFT_RST_OFS});

   // shadow of soft reset and global enable; control writes are dropped while soft reset holds
   always_ff @(posedge i_clk_sys or posedge i_reset) begin
      if (i_reset) begin
         srst_q <= 1'b1;
         en_q   <= 1'b0;
      end else begin
         if (acc && i_apb.pwrite && i_apb.paddr == SOFT_RST_OFS) srst_q <= i_apb.pwdata[SOFT_RST_BIT];
         if (!srst_q) en_q <= 1'b0;
         else if (acc && i_apb.pwrite && i_apb.paddr == CTRL_OFS) en_q <= i_apb.pwdata[CTRL_IRQ_EN_BIT];
      end
   end

   // =====================================================================
   // assertions
   a_reset_release: assert property ($fell(i_reset) |-> o_cpu_interrupt_request_n)
      else $error("request low right after reset");
   a_one_wait: assert property (setup |=> o_pready)
      else $error("no answer one cycle after setup");
   a_ready_pulse: assert property (o_pready |=> !o_pready)
      else $error("ready held longer than one cycle");
   a_err_ready: assert property (o_pslverr |-> o_pready)
      else $error("error flag without ready");
   a_err_map: assert property (setup |=> o_pslverr == !$past(mapped))
      else $error("error flag does not match address map");
   a_read_release: assert property (vec_rd |-> ##2 o_cpu_interrupt_request_n)
      else $error("request not released after vector read");
   a_en_masks: assert property ((!en_q) [*3] |-> o_cpu_interrupt_request_n)
      else $error("request low while globally disabled");
   a_release_cause: assert property ($rose(o_cpu_interrupt_request_n) |->
      $past(vec_rd, 2) || !$past(en_q) || !$past(srst_q))
      else $error("request released without vector read");
   // a refused access must not leak register contents
   a_err_data: assert property (o_pslverr |-> o_prdata == 32'h0000_0000)
      else $error("read data not zero on error answer");

   // main scenarios reached
   c_req_low: cover property ($fell(o_cpu_interrupt_request_n));
   c_vec_rd: cover property (vec_rd && o_cpu_interrupt_request_n == 1'b0);
   c_slverr: cover property (o_pslverr);
   c_src_req: cover property (i_irq_src != '0 && !o_cpu_interrupt_request_n);
endmodule

bind vectored_irq_controller vic_asserts u_vic_asserts (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
   .i_clk_en(i_clk_en), .i_apb(i_apb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_irq_src(i_irq_src), .o_cpu_interrupt_request_n(o_cpu_interrupt_request_n));
`default_nettype wire
